// file: rtl/uver_event_regs.sv
// Bus power event enables, live status, event latch, line state debug and scratch registers.
// Operation
// - An enabled high-to-low status change latches an event and requests an RXCMD.
// - All falling-edge enable bits come out of reset set to one.
// - Fall enable bits: 3 session end, 2 session valid, 1 bus power, 0 disconnect.
// - Status at 13h returns the live, unlatched source levels on every read.
// - Status bits: 3 session end, 2 session valid, 1 bus power, 0 disconnect.
// - A latch bit sets on an enabled change of its source, same positions.
// - Reading the latch register clears all its bits but those set by an event in the same cycle.
// - Entering low-power or serial mode clears all latch bits but those set by an event in the same cycle.
// - Debug at 15h shows line state in bits 1:0, upper bits zero.
// - Scratch byte resets to zero; read 16h-18h, write 16h, set 17h, clear 18h.
// - Accesses to 19h through 2Eh change no state.
// - Rising-edge enable at 0Dh-0Fh gates zero-to-one changes of the same sources.
`include "uver_defs.svh"
module uver_event_regs
    import uver_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`UVER_ADDR_W-1:0] reg_addr_i,
    input wire logic [`UVER_DATA_W-1:0] reg_wdata_i,
    output logic [`UVER_DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic session_over_comparator_i,
    input wire logic session_valid_comparator_i,
    input wire logic bus_power_valid_comparator_i,
    input wire logic host_disconnect_detector_i,
    input wire logic line_state_high_bit_i,
    input wire logic line_state_low_bit_i,
    input wire logic low_power_mode_i,
    input wire logic serial_mode_i,
    output logic rxcmd_req_o,
    input wire logic rxcmd_ack_i,
    output logic [`UVER_SRC_W-1:0] rxcmd_status_o
);
    logic [`UVER_SRC_W-1:0] src_raw;
    logic [`UVER_SRC_W-1:0] src_level;
    logic [`UVER_SRC_W-1:0] src_rise;
    logic [`UVER_SRC_W-1:0] src_fall;
    logic [`UVER_LS_W-1:0] ls_level;
    logic [`UVER_DATA_W-1:0] rise_en;
    logic [`UVER_DATA_W-1:0] fall_en;
    logic [`UVER_DATA_W-1:0] scratch;
    uver_op_t rise_op;
    uver_op_t fall_op;
    uver_op_t scratch_op;
    logic [`UVER_SRC_W-1:0] event_vec;
    logic [`UVER_SRC_W-1:0] latch_reg;
    logic [`UVER_SRC_W-1:0] latch_next;
    logic latch_rd_clr;
    logic mode_clr;
    logic low_power_q_reg;
    logic serial_q_reg;
    logic [`UVER_DATA_W-1:0] rdata_reg;
    logic [`UVER_DATA_W-1:0] rdata_next;
    logic rvalid_reg;
    uver_rx_state_t rx_state_reg;
    logic [`UVER_SRC_W-1:0] rx_status_reg;
    logic unimpl_hit;

    // Status bit order: session end, session valid, bus power valid, disconnect.
    always_comb begin
        src_raw = '0;
        src_raw[`UVER_BIT_SESSION_OVER] = session_over_comparator_i;
        src_raw[`UVER_BIT_SESSION_OK] = session_valid_comparator_i;
        src_raw[`UVER_BIT_BUS_POWER_OK] = bus_power_valid_comparator_i;
        src_raw[`UVER_BIT_DISCONNECT] = host_disconnect_detector_i;
    end

    // The comparators are analog and asynchronous to the link clock.
    uver_sync_edge #(
        .WIDTH(`UVER_SRC_W)
    ) u_src_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .raw_i(src_raw),
        .level_o(src_level),
        .rise_o(src_rise),
        .fall_o(src_fall)
    );

    uver_sync_edge #(
        .WIDTH(`UVER_LS_W)
    ) u_ls_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .raw_i({line_state_high_bit_i, line_state_low_bit_i}),
        .level_o(ls_level),
        .rise_o(),
        .fall_o()
    );

    assign unimpl_hit = (reg_addr_i >= `UVER_UNIMPL_LO) && (reg_addr_i <= `UVER_UNIMPL_HI);

    // Only the exact write, set and clear addresses decode to an operation.
    always_comb begin
        rise_op = UVER_OP_NONE;
        fall_op = UVER_OP_NONE;
        scratch_op = UVER_OP_NONE;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `UVER_RISE_EN_WR: rise_op = UVER_OP_WRITE;
                `UVER_RISE_EN_SET: rise_op = UVER_OP_SET;
                `UVER_RISE_EN_CLR: rise_op = UVER_OP_CLEAR;
                `UVER_FALL_EN_WR: fall_op = UVER_OP_WRITE;
                `UVER_FALL_EN_SET: fall_op = UVER_OP_SET;
                `UVER_FALL_EN_CLR: fall_op = UVER_OP_CLEAR;
                `UVER_SCRATCH_WR: scratch_op = UVER_OP_WRITE;
                `UVER_SCRATCH_SET: scratch_op = UVER_OP_SET;
                `UVER_SCRATCH_CLR: scratch_op = UVER_OP_CLEAR;
                default: scratch_op = UVER_OP_NONE;
            endcase
        end
    end

    uver_wsc_reg #(
        .WIDTH(`UVER_DATA_W),
        .RESET_VAL(`UVER_RISE_EN_RESET)
    ) u_rise_en (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .op_i(rise_op),
        .wdata_i(reg_wdata_i),
        .q_o(rise_en)
    );

    // Every monitored falling transition is reported until the link masks it.
    uver_wsc_reg #(
        .WIDTH(`UVER_DATA_W),
        .RESET_VAL(`UVER_FALL_EN_RESET)
    ) u_fall_en (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .op_i(fall_op),
        .wdata_i(reg_wdata_i),
        .q_o(fall_en)
    );

    uver_wsc_reg #(
        .WIDTH(`UVER_DATA_W),
        .RESET_VAL(`UVER_SCRATCH_RESET)
    ) u_scratch (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .op_i(scratch_op),
        .wdata_i(reg_wdata_i),
        .q_o(scratch)
    );

    // The low nibble of each enable lines up with the status bits.
    assign event_vec = (src_rise & rise_en[`UVER_SRC_W-1:0])
        | (src_fall & fall_en[`UVER_SRC_W-1:0]);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_power_q_reg <= 1'b0;
            serial_q_reg <= 1'b0;
        end else begin
            low_power_q_reg <= low_power_mode_i;
            serial_q_reg <= serial_mode_i;
        end
    end

    assign mode_clr = (low_power_mode_i & ~low_power_q_reg) | (serial_mode_i & ~serial_q_reg);
    assign latch_rd_clr = reg_rd_i && (reg_addr_i == `UVER_LATCH_ADDR);

    // A new event in the clearing cycle survives, so no change is ever lost.
    always_comb begin
        latch_next = latch_reg;
        if (latch_rd_clr || mode_clr) begin
            latch_next = `UVER_LATCH_RESET;
        end
        latch_next = latch_next | event_vec;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            latch_reg <= `UVER_LATCH_RESET;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Read data is captured from the value before any read side effect.
    always_comb begin
        case (reg_addr_i)
            `UVER_RISE_EN_WR, `UVER_RISE_EN_SET, `UVER_RISE_EN_CLR: rdata_next = rise_en;
            `UVER_FALL_EN_WR, `UVER_FALL_EN_SET, `UVER_FALL_EN_CLR: rdata_next = fall_en;
            `UVER_STATUS_ADDR: rdata_next = {`UVER_STATUS_PAD, src_level};
            `UVER_LATCH_ADDR: rdata_next = {`UVER_STATUS_PAD, latch_reg};
            `UVER_DEBUG_ADDR: rdata_next = {`UVER_DEBUG_PAD, ls_level};
            `UVER_SCRATCH_WR, `UVER_SCRATCH_SET, `UVER_SCRATCH_CLR: rdata_next = scratch;
            default: rdata_next = `UVER_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= `UVER_BYTE_ZERO;
        end else if (reg_rd_i) begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd_i;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;

    // Events pending an RXCMD merge; the snapshot carries the levels seen at the most recent enabled event.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_state_reg <= UVER_RX_IDLE;
        end else begin
            case (rx_state_reg)
                UVER_RX_IDLE: begin
                    if (event_vec != '0) begin
                        rx_state_reg <= UVER_RX_PEND;
                    end
                end
                UVER_RX_PEND: begin
                    if (rxcmd_ack_i && event_vec == '0) begin
                        rx_state_reg <= UVER_RX_IDLE;
                    end
                end
                default: rx_state_reg <= UVER_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_status_reg <= '0;
        end else if (event_vec != '0) begin
            rx_status_reg <= src_level;
        end
    end

    assign rxcmd_req_o = (rx_state_reg == UVER_RX_PEND);
    assign rxcmd_status_o = rx_status_reg;

    chk_fall_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((src_fall & fall_en[`UVER_SRC_W-1:0]) != '0)
        |=> ((latch_reg & $past(src_fall) & $past(fall_en[`UVER_SRC_W-1:0]))
        == ($past(src_fall) & $past(fall_en[`UVER_SRC_W-1:0]))))
        else $error("Enabled falling change not latched.");

    chk_rise_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((src_rise & rise_en[`UVER_SRC_W-1:0]) != '0)
        |=> ((latch_reg & $past(src_rise) & $past(rise_en[`UVER_SRC_W-1:0]))
        == ($past(src_rise) & $past(rise_en[`UVER_SRC_W-1:0]))))
        else $error("Enabled rising change not latched.");

    chk_event_rxcmd: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (event_vec != '0) |=> rxcmd_req_o && (rxcmd_status_o == $past(src_level)))
        else $error("Event did not raise an RXCMD request.");

    chk_fall_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == `UVER_FALL_EN_SET) |=> fall_en == ($past(fall_en) | $past(reg_wdata_i)))
        else $error("Set access did not OR the byte in.");

    chk_fall_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == `UVER_FALL_EN_CLR) |=> fall_en == ($past(fall_en) & ~$past(reg_wdata_i)))
        else $error("Clear access did not remove the given bits.");

    chk_status_live: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == `UVER_STATUS_ADDR)
        |=> reg_rvalid_o && reg_rdata_o == {`UVER_STATUS_PAD, $past(src_level)})
        else $error("Status read did not return live levels.");

    chk_latch_rdclr: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (latch_rd_clr && event_vec == '0) |=> latch_reg == `UVER_LATCH_RESET ##1 latch_reg == $past(event_vec))
        else $error("Latch not cleared by its read.");

    chk_mode_clr: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (mode_clr && event_vec == '0) |=> latch_reg == `UVER_LATCH_RESET)
        else $error("Latch not cleared on mode entry.");

    chk_debug_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == `UVER_DEBUG_ADDR) |=> reg_rdata_o == {`UVER_DEBUG_PAD, $past(ls_level)})
        else $error("Debug read did not show the line state.");

    chk_unimpl_stable: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && unimpl_hit) |=> $stable(fall_en) && $stable(rise_en) && $stable(scratch))
        else $error("Unimplemented address changed state.");

    chk_scratch_wr: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_wr_i && reg_addr_i == `UVER_SCRATCH_WR) |=> scratch == $past(reg_wdata_i) && $stable(fall_en))
        else $error("Scratch write failed or disturbed other state.");

    cov_fall_event: cover property (@(posedge clk_i) disable iff (!resetn_i)
        (src_fall & fall_en[`UVER_SRC_W-1:0]) != '0);
    cov_set_clear_race: cover property (@(posedge clk_i) disable iff (!resetn_i)
        latch_rd_clr && event_vec != '0);
    cov_rxcmd_ack: cover property (@(posedge clk_i) disable iff (!resetn_i)
        rxcmd_req_o ##1 rxcmd_ack_i ##1 !rxcmd_req_o);
endmodule

// file: rtl/uver_defs.svh
// Register addresses, reset values, field positions and sync depth for the bus power event registers.
`ifndef UVER_DEFS_SVH
`define UVER_DEFS_SVH

`define UVER_ADDR_W 6
`define UVER_DATA_W 8
`define UVER_SRC_W 4
`define UVER_LS_W 2

`define UVER_RISE_EN_WR 6'h0d
`define UVER_RISE_EN_SET 6'h0e
`define UVER_RISE_EN_CLR 6'h0f
`define UVER_FALL_EN_WR 6'h10
`define UVER_FALL_EN_SET 6'h11
`define UVER_FALL_EN_CLR 6'h12
`define UVER_STATUS_ADDR 6'h13
`define UVER_LATCH_ADDR 6'h14
`define UVER_DEBUG_ADDR 6'h15
`define UVER_SCRATCH_WR 6'h16
`define UVER_SCRATCH_SET 6'h17
`define UVER_SCRATCH_CLR 6'h18
`define UVER_UNIMPL_LO 6'h19
`define UVER_UNIMPL_HI 6'h2e

`define UVER_RISE_EN_RESET 8'h1f
`define UVER_FALL_EN_RESET 8'h1f
`define UVER_SCRATCH_RESET 8'h00
`define UVER_LATCH_RESET 4'h0
`define UVER_STATUS_PAD 4'h0
`define UVER_DEBUG_PAD 6'h00
`define UVER_BYTE_ZERO 8'h00

`define UVER_BIT_SESSION_OVER 3
`define UVER_BIT_SESSION_OK 2
`define UVER_BIT_BUS_POWER_OK 1
`define UVER_BIT_DISCONNECT 0

`define UVER_SYNC_STAGES 2

`endif

// file: rtl/uver_pkg.sv
// Types shared by the bus power event register modules.
package uver_pkg;
    typedef enum logic [1:0] {
        UVER_OP_NONE,
        UVER_OP_WRITE,
        UVER_OP_SET,
        UVER_OP_CLEAR
    } uver_op_t;

    typedef enum logic {
        UVER_RX_IDLE,
        UVER_RX_PEND
    } uver_rx_state_t;
endpackage

// file: rtl/uver_sync_edge.sv
// Two-stage synchroniser with edge detection for a group of asynchronous levels.
module uver_sync_edge
    import uver_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] raw_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    // The first stage feeds only the second; edges are taken after the second.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                    prev_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= raw_i[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    prev_reg[gi] <= sync_reg[gi];
                end
            end
            assign rise_o[gi] = sync_reg[gi] & ~prev_reg[gi];
            assign fall_o[gi] = ~sync_reg[gi] & prev_reg[gi];
        end
    endgenerate

    assign level_o = sync_reg;
endmodule

// file: rtl/uver_wsc_reg.sv
// Byte register with write, set and clear operations.
module uver_wsc_reg
    import uver_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire uver_op_t op_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // Set ORs the byte in; clear removes exactly the bits given as ones.
    always_comb begin
        case (op_i)
            UVER_OP_WRITE: q_next = wdata_i;
            UVER_OP_SET: q_next = q_reg | wdata_i;
            UVER_OP_CLEAR: q_next = q_reg & ~wdata_i;
            default: q_next = q_reg;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_reg <= RESET_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule

// file: sim/uver_link_model.sv
// Link-side model that acknowledges RXCMD requests after a short or long delay.
module uver_link_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic rxcmd_req_i,
    input wire logic slow_i,
    output logic rxcmd_ack_o,
    output logic [7:0] ack_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_reg;
    // Events are taken from RXCMDs only, so the latch is never read here.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxcmd_ack_o <= 1'b0;
            wait_reg <= 2'h0;
            ack_count_o <= 8'h00;
        end else if (rxcmd_ack_o) begin
            rxcmd_ack_o <= 1'b0;
        end else if (rxcmd_req_i && (wait_reg == (slow_i ? 2'h3 : 2'h0))) begin
            rxcmd_ack_o <= 1'b1;
            wait_reg <= 2'h0;
            ack_count_o <= ack_count_o + 8'h01;
        end else if (rxcmd_req_i) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// file: sim/tb_uver_event_regs.sv
// Self-checking bench for the bus power event registers.
`include "uver_defs.svh"
module tb_uver_event_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] src = 4'h0;
    logic [1:0] ls = 2'h0;
    logic lp = 1'b0;
    logic ser = 1'b0;
    logic req;
    logic ack;
    logic slow = 1'b0;
    logic [7:0] acks;
    logic [3:0] snap;
    logic [31:0] rnd = 32'hcd77a88e;
    int n_mismatch = 0;
    int cmp_count = 0;

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    uver_event_regs i_uver_event_regs (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd_s),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .session_over_comparator_i(src[3]), .session_valid_comparator_i(src[2]),
        .bus_power_valid_comparator_i(src[1]), .host_disconnect_detector_i(src[0]),
        .line_state_high_bit_i(ls[1]), .line_state_low_bit_i(ls[0]), .low_power_mode_i(lp),
        .serial_mode_i(ser), .rxcmd_req_o(req), .rxcmd_ack_i(ack), .rxcmd_status_o(snap));
    uver_link_model i_uver_link_model (.clk_i(clk_i), .resetn_i(resetn_i), .rxcmd_req_i(req), .slow_i(slow),
        .rxcmd_ack_o(ack), .ack_count_o(acks));

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected value of a write, set or clear register after one access.
    function automatic logic [7:0] wsc(logic [7:0] cur, int op, logic [7:0] d);
        return (op == 0) ? d : (op == 1) ? (cur | d) : (cur & ~d);
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Every task ends one time unit after a rising edge.
    task automatic wait_cyc(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic reg_wr(logic [5:0] a, logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        wait_cyc(1);
        wr = 1'b0;
        // One idle edge keeps the next access from raising the strobe in the step it is lowered.
        wait_cyc(1);
    endtask

    task automatic reg_rd(logic [5:0] a, output logic [7:0] d);
        bit seen;
        seen = 0;
        d = 8'hxx;
        rd_s = 1'b1;
        addr = a;
        // The valid pulse stands only between the edge after the strobe and the next one.
        for (int i = 0; i < 3 && !seen; i++) begin
            wait_cyc(1);
            rd_s = 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                seen = 1;
            end
        end
        wait_cyc(1);
        if (!seen) begin
            cmp_byte("read valid", 8'h01, 8'h00);
        end
    endtask

    task automatic rd_cmp(logic [5:0] a, logic [7:0] exp, string what);
        logic [7:0] d;
        reg_rd(a, d);
        cmp_byte(what, exp, d);
    endtask

    initial begin
        #200us;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        logic [5:0] base [3];
        logic [7:0] mdl [3];
        logic [7:0] n0;
        int op;
        base = '{`UVER_FALL_EN_WR, `UVER_SCRATCH_WR, `UVER_RISE_EN_WR};
        mdl = '{`UVER_FALL_EN_RESET, `UVER_SCRATCH_RESET, `UVER_RISE_EN_RESET};
        repeat (2) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        wait_cyc(1);
        // Reset values, then random write, set and clear with readback at all three addresses.
        for (int b = 0; b < 3; b++) begin
            rd_cmp(base[b], mdl[b], "reset value");
            for (int i = 0; i < 6; i++) begin
                rnd = lfsr_next(rnd);
                op = rnd[9:8] % 3;
                reg_wr(base[b] + op[5:0], rnd[7:0]);
                mdl[b] = wsc(mdl[b], op, rnd[7:0]);
                for (int j = 0; j < 3; j++) begin
                    rd_cmp(base[b] + j[5:0], mdl[b], "wsc register");
                end
            end
        end
        rd_cmp(`UVER_LATCH_ADDR, 8'h00, "latch at reset");
        $display("test wsc done");
        // Live levels with random sources and line state, all edges masked so the latch stays empty.
        reg_wr(`UVER_FALL_EN_WR, 8'h00);
        reg_wr(`UVER_RISE_EN_WR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            src = rnd[3:0];
            ls = rnd[5:4];
            wait_cyc(4);
            rd_cmp(`UVER_STATUS_ADDR, {4'h0, src}, "status");
            rd_cmp(`UVER_DEBUG_ADDR, {6'h00, ls}, "debug");
        end
        $display("test status done");
        reg_wr(`UVER_FALL_EN_WR, 8'h0f);
        reg_wr(`UVER_RISE_EN_WR, 8'h00);
        src = 4'hf;
        wait_cyc(8);
        rd_cmp(`UVER_LATCH_ADDR, 8'h00, "latch cleared");
        wait_cyc(1);
        rd_cmp(`UVER_LATCH_ADDR, 8'h00, "latch after clear");
        // One falling edge per source, each must reach the latch and one RXCMD.
        for (int k = 0; k < 4; k++) begin
            slow = k[0];
            n0 = acks;
            src[k] = 1'b0;
            wait_cyc(6);
            rd_cmp(`UVER_LATCH_ADDR, 8'h01 << k, "latch bit");
            rd_cmp(`UVER_LATCH_ADDR, 8'h00, "latch read clear");
            cmp_byte("rxcmd status", {4'h0, src}, {4'h0, snap});
            cmp_byte("rxcmd count", n0 + 8'h01, acks);
            src[k] = 1'b1;
            wait_cyc(6);
            rd_cmp(`UVER_LATCH_ADDR, 8'h00, "masked rise");
        end
        // A masked fall on source 2 is ignored and leaves the latch empty.
        reg_wr(`UVER_FALL_EN_CLR, 8'h04);
        src = 4'hb;
        wait_cyc(6);
        rd_cmp(`UVER_LATCH_ADDR, 8'h00, "masked fall");
        src = 4'hf;
        wait_cyc(6);
        // An enabled rise on the same source is latched although its fall is masked.
        reg_wr(`UVER_RISE_EN_SET, 8'h04);
        src = 4'hb;
        wait_cyc(6);
        src = 4'hf;
        wait_cyc(6);
        rd_cmp(`UVER_LATCH_ADDR, 8'h04, "enabled rise");
        reg_wr(`UVER_RISE_EN_CLR, 8'h04);
        $display("test events done");
        // Entering either mode empties the latch.
        reg_wr(`UVER_FALL_EN_WR, 8'h0f);
        for (int m = 0; m < 2; m++) begin
            src[0] = 1'b0;
            wait_cyc(6);
            if (m == 0) lp = 1'b1;
            else ser = 1'b1;
            wait_cyc(3);
            rd_cmp(`UVER_LATCH_ADDR, 8'h00, "mode clear");
            lp = 1'b0;
            ser = 1'b0;
            src[0] = 1'b1;
            wait_cyc(6);
        end
        $display("test modes done");
        // Unmapped addresses read zero and disturb nothing.
        for (int a = `UVER_UNIMPL_LO; a <= `UVER_UNIMPL_HI; a++) begin
            rnd = lfsr_next(rnd);
            reg_wr(a[5:0], rnd[7:0]);
            rd_cmp(a[5:0], 8'h00, "unmapped");
        end
        rd_cmp(`UVER_FALL_EN_WR, 8'h0f, "fall enable kept");
        rd_cmp(`UVER_SCRATCH_WR, mdl[1], "scratch kept");
        rd_cmp(`UVER_LATCH_ADDR, 8'h00, "latch kept");
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
